// ---- adc_out_cfg.svh ----
// Constants for the converter output and mode-control block
`ifndef ADC_OUT_CFG_SVH
`define ADC_OUT_CFG_SVH

// Sample width and pipeline depth in encode cycles
`define SAMPLE_W 10
`define PIPE_LATENCY 5
`define PIPE_DEPTH 6

// Multi-level pin codes: 0V, 1/3 supply, 2/3 supply, full supply
`define LEVEL_GND 2'h0
`define LEVEL_THIRD 2'h1
`define LEVEL_TWO_THIRDS 2'h2
`define LEVEL_SUPPLY 2'h3

// Register byte offsets
`define REG_STATUS 8'h00
`define REG_MASK 8'h04
`define REG_STATE 8'h08
`define REG_COUNT 8'h0C

// Status and mask bit positions
`define EV_RANGE 0
`define EV_MODE 1
`define EV_DATA 2
`define EV_W 3

// Reset values
`define RST_MASK 3'h0
`define RST_WORD 32'h0000_0000
`define RST_COUNT 16'h0000

// AHB encodings used by the slave
`define HSIZE_WORD 3'h2
`define HRESP_OKAY 1'b0

`endif

// ---- adc_out_pkg.sv ----
// Types shared by the converter output and mode-control block
package adc_out_pkg;
`include "adc_out_cfg.svh"

   typedef enum logic [1:0] {
      OUT_FULL = 2'h0,
      OUT_SIMUL = 2'h1,
      OUT_INTER = 2'h3,
      OUT_DIFF = 2'h2
   } out_mode_e;

   typedef enum logic [1:0] {
      PWR_NORMAL = 2'h0,
      PWR_NAP = 2'h1,
      PWR_SLEEP = 2'h3
   } power_e;

   typedef struct packed {
      logic range;
      logic [`SAMPLE_W-1:0] code;
   } sample_s;

endpackage

// ---- adc_out_properties.sv ----
// Port checks for the converter output block
`timescale 1ns/1ps
`include "adc_out_cfg.svh"
module adc_out_properties (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic [1:0] format_level_i,
   input wire logic [1:0] output_mode_level_i,
   input wire logic power_down_select_i,
   input wire logic output_enable_n_i,
   input wire logic [`SAMPLE_W-1:0] diff_sample_bits_pos_o,
   input wire logic [`SAMPLE_W-1:0] diff_sample_bits_neg_o,
   input wire logic valid_strobe_pos_o,
   input wire logic valid_strobe_neg_o,
   input wire logic range_flag_pos_o,
   input wire logic range_flag_neg_o,
   input wire logic diff_oe_o,
   input wire logic first_bus_oe_o,
   input wire logic second_bus_oe_o,
   input wire logic second_strobe_oe_o,
   input wire logic stabilizer_on_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   logic [5:0] last;
   logic [2:0] calm;
   wire [5:0] pins = {format_level_i, output_mode_level_i, power_down_select_i, output_enable_n_i};
   wire [1:0] m = output_mode_level_i;
   wire on = !power_down_select_i && !output_enable_n_i;
   wire any_oe = diff_oe_o | first_bus_oe_o | second_bus_oe_o | second_strobe_oe_o;
   // Pins pass synchronizers, so judge only after they stood seven cycles
   wire ok = (calm == 3'h7) && (pins == last);
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         last <= 6'h00;
         calm <= 3'h0;
      end else begin
         last <= pins;
         calm <= (pins != last) ? 3'h0 : calm + {2'h0, !ok};
      end
   end
   a_stab_level: assert property (ok && on |-> stabilizer_on_o == ^format_level_i)
      else $error("stabilizer wrong");
   a_nap_float: assert property (ok && power_down_select_i |-> !any_oe [*3])
      else $error("driven in power-down");
   a_oe_float: assert property (ok && output_enable_n_i |-> !any_oe)
      else $error("driven while disabled");
   a_run_drives: assert property (ok && on |-> any_oe)
      else $error("not driven in normal run");
   a_full_float: assert property (ok && on && m == 2'h0 |-> first_bus_oe_o &&
      second_strobe_oe_o && !second_bus_oe_o && !diff_oe_o) else $error("full mode enables");
   a_demux_both: assert property (ok && on && ^m |-> first_bus_oe_o &&
      second_bus_oe_o && !diff_oe_o) else $error("demux enables");
   a_diff_only: assert property (ok && on && m == 2'h3 |-> diff_oe_o &&
      !first_bus_oe_o && !second_strobe_oe_o) else $error("differential enables");
   a_flag_pair: assert property (range_flag_neg_o != range_flag_pos_o)
      else $error("range pair not complementary");
   a_bits_pair: assert property (diff_sample_bits_neg_o == ~diff_sample_bits_pos_o)
      else $error("data pair not complementary");
   a_strobe_pair: assert property (valid_strobe_neg_o != valid_strobe_pos_o)
      else $error("strobe pair not complementary");
   c_simul: cover property (ok && on && m == 2'h1);
   c_nap: cover property (ok && power_down_select_i && !output_enable_n_i);
   c_sleep: cover property (ok && power_down_select_i && output_enable_n_i);
endmodule

// ---- adc_output_mode_interface.sv ----
// Output formatting, bus steering and mode control of a 10-bit pipelined converter
`timescale 1ns/1ps
`include "adc_out_cfg.svh"

module adc_output_mode_interface
   import adc_out_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic sample_clock_pos_i,
   input wire logic sample_clock_neg_i,
   input wire logic [`SAMPLE_W-1:0] sample_code_i,
   input wire logic sample_range_i,
   input wire logic [1:0] format_level_i,
   input wire logic [1:0] output_mode_level_i,
   input wire logic power_down_select_i,
   input wire logic output_enable_n_i,
   output logic [`SAMPLE_W-1:0] diff_sample_bits_pos_o,
   output logic [`SAMPLE_W-1:0] diff_sample_bits_neg_o,
   output logic range_flag_pos_o,
   output logic range_flag_neg_o,
   output logic valid_strobe_pos_o,
   output logic valid_strobe_neg_o,
   output logic diff_oe_o,
   output logic [`SAMPLE_W-1:0] first_bus_bits_o,
   output logic first_bus_range_flag_o,
   output logic first_bus_strobe_o,
   output logic first_bus_oe_o,
   output logic [`SAMPLE_W-1:0] second_bus_bits_o,
   output logic second_bus_range_flag_o,
   output logic second_bus_oe_o,
   output logic second_bus_strobe_o,
   output logic second_strobe_oe_o,
   output logic stabilizer_on_o,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic irq_o
);

   function automatic out_mode_e level_to_mode(input logic [1:0] lvl);
      unique case (lvl)
         `LEVEL_GND: level_to_mode = OUT_FULL;
         `LEVEL_THIRD: level_to_mode = OUT_SIMUL;
         `LEVEL_TWO_THIRDS: level_to_mode = OUT_INTER;
         `LEVEL_SUPPLY: level_to_mode = OUT_DIFF;
      endcase
   endfunction

   // Offset binary is the core's native code; two's complement flips the MSB only
   function automatic sample_s to_format(input sample_s s, input logic twos);
      to_format = s;
      to_format.code[`SAMPLE_W-1] = s.code[`SAMPLE_W-1] ^ twos;
   endfunction

   // Pin synchronisers: first stage feeds only the second
   logic [1:0] enc_s1, enc_s2;
   logic [1:0] fmt_s1, fmt_s2, omode_s1, omode_s2;
   logic pd_s1, pd_s2, oen_s1, oen_s2;
   sample_s smp_s1, smp_s2;
   logic enc_q;

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         enc_s1 <= 2'h0;
         enc_s2 <= 2'h0;
         fmt_s1 <= 2'h0;
         fmt_s2 <= 2'h0;
         omode_s1 <= 2'h0;
         omode_s2 <= 2'h0;
         pd_s1 <= 1'b1;
         pd_s2 <= 1'b1;
         oen_s1 <= 1'b1;
         oen_s2 <= 1'b1;
         smp_s1 <= '0;
         smp_s2 <= '0;
         enc_q <= 1'b0;
      end else begin
         enc_s1 <= {sample_clock_pos_i, sample_clock_neg_i};
         enc_s2 <= enc_s1;
         fmt_s1 <= format_level_i;
         fmt_s2 <= fmt_s1;
         omode_s1 <= output_mode_level_i;
         omode_s2 <= omode_s1;
         pd_s1 <= power_down_select_i;
         pd_s2 <= pd_s1;
         oen_s1 <= output_enable_n_i;
         oen_s2 <= oen_s1;
         smp_s1 <= '{range: sample_range_i, code: sample_code_i};
         smp_s2 <= smp_s1;
         enc_q <= enc_s2[1] & ~enc_s2[0];
      end
   end

   // Encode is high while the positive line is above the negative one
   wire enc_lvl = enc_s2[1] & ~enc_s2[0];

   // Rise is seen two system clocks late, so codes must hold that long around it
   wire enc_rise = enc_lvl & ~enc_q;

   // Format pin: upper bit picks the code, the two middle levels turn the stabilizer on
   wire twos = fmt_s2[1];
   wire stab_next = fmt_s2[1] ^ fmt_s2[0];

   // Output-mode pin is decoded here and registered with the power state
   wire out_mode_e mode_next = level_to_mode(omode_s2);

   // Nap and sleep both stop the pipeline; they differ only in what software reads
   wire power_e power_next = !pd_s2 ? PWR_NORMAL : (oen_s2 ? PWR_SLEEP : PWR_NAP);
   power_e power;
   out_mode_e mode;

   // Output enable gates only the drivers; conversion goes on behind them
   wire running = (power == PWR_NORMAL);
   wire drive = running & ~oen_s2;

   // Pipeline, bus data and toggle move on detected encode rises only; strobes follow the encode level outside the two demux modes
   wire step = enc_rise & running;
   wire demux = (mode == OUT_SIMUL) || (mode == OUT_INTER);

   // Pipeline stands still in nap and sleep, so no sample is lost or invented
   sample_s pipe [1:`PIPE_DEPTH];
   logic tog;
   wire next_tog = tog ^ step;

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 1; i <= `PIPE_DEPTH; i++) begin
            pipe[i] <= '0;
         end
      end else if (step) begin
         pipe[1] <= smp_s2;
         for (int i = 2; i <= `PIPE_DEPTH; i++) begin
            pipe[i] <= pipe[i-1];
         end
      end
   end

   wire sample_s new5 = to_format(pipe[`PIPE_LATENCY], twos);
   wire sample_s new6 = to_format(pipe[`PIPE_DEPTH], twos);

   // Which bus takes a sample on this encode edge
   wire load_a = step & ((mode == OUT_FULL) || (mode == OUT_DIFF) || (demux && !tog));
   wire load_b = step & ((mode == OUT_INTER && tog) || (mode == OUT_SIMUL && !tog));

   // Simultaneous update pairs the older sample on the first bus with the newer on the second
   wire sample_s a_next = (mode == OUT_SIMUL) ? new6 : new5;
   wire is_diff = (mode == OUT_DIFF);
   wire strobe_next = demux ? next_tog : enc_lvl;

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         power <= PWR_SLEEP;
         mode <= OUT_FULL;
         tog <= 1'b0;
         stabilizer_on_o <= 1'b0;
      end else begin
         power <= power_next;
         mode <= mode_next;
         tog <= demux ? next_tog : 1'b0;
         stabilizer_on_o <= stab_next;
      end
   end

   // Differential bus: pos and neg lines are separate flops so both leave straight from registers
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         diff_sample_bits_pos_o <= '0;
         diff_sample_bits_neg_o <= '1;
         range_flag_pos_o <= 1'b0;
         range_flag_neg_o <= 1'b1;
         valid_strobe_pos_o <= 1'b0;
         valid_strobe_neg_o <= 1'b1;
         diff_oe_o <= 1'b0;
      end else begin
         if (load_a && is_diff) begin
            diff_sample_bits_pos_o <= new5.code;
            diff_sample_bits_neg_o <= ~new5.code;
            range_flag_pos_o <= new5.range;
            range_flag_neg_o <= ~new5.range;
         end
         // Data moves at encode rise, so the positive strobe falls mid-sample
         valid_strobe_pos_o <= enc_lvl;
         valid_strobe_neg_o <= ~enc_lvl;
         diff_oe_o <= drive & is_diff;
      end
   end

   // Single-ended buses
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         first_bus_bits_o <= '0;
         first_bus_range_flag_o <= 1'b0;
         first_bus_strobe_o <= 1'b0;
         first_bus_oe_o <= 1'b0;
         second_bus_bits_o <= '0;
         second_bus_range_flag_o <= 1'b0;
         second_bus_strobe_o <= 1'b0;
         second_bus_oe_o <= 1'b0;
         second_strobe_oe_o <= 1'b0;
      end else begin
         if (load_a && !is_diff) begin
            first_bus_bits_o <= a_next.code;
            first_bus_range_flag_o <= a_next.range;
         end
         if (load_b) begin
            second_bus_bits_o <= new5.code;
            second_bus_range_flag_o <= new5.range;
         end
         first_bus_strobe_o <= strobe_next;
         second_bus_strobe_o <= demux ? ~next_tog : enc_lvl;
         first_bus_oe_o <= drive & !is_diff;
         second_bus_oe_o <= drive & demux;
         second_strobe_oe_o <= drive & !is_diff;
      end
   end

   // Events for software
   wire delivered = load_a | load_b;

   // Range event counts only samples that actually left on a bus
   wire range_hit = (load_a & (is_diff ? new5.range : a_next.range)) | (load_b & new5.range);

   // Output-mode and power pin changes raise an event; a format pin change raises none
   wire mode_hit = (mode_next != mode) || (power_next != power);
   wire [`EV_W-1:0] ev_set = {delivered, mode_hit, range_hit};

   // AHB-Lite slave, zero wait states
   wire acc = hsel_i & hready_i & htrans_i[1] & (hsize_i == `HSIZE_WORD);

   // Only the low address byte is decoded, so the map repeats every 256 bytes
   wire [7:0] idx = haddr_i[7:0];
   wire rd_acc = acc & ~hwrite_i;

   logic [`EV_W-1:0] status, mask;
   logic [15:0] count;
   logic wr_pend;
   logic [7:0] wr_idx;


   // Read-only view of the pin decode as the block applies it
   wire [31:0] state_word = {26'h000_0000, stabilizer_on_o, twos, mode, power};

   // Unmapped offsets read as zero, so probing the map is harmless
   wire [31:0] rd_val =
      (idx == `REG_STATUS) ? {29'h0000_0000, status} :
      (idx == `REG_MASK) ? {29'h0000_0000, mask} :
      (idx == `REG_STATE) ? state_word :
      (idx == `REG_COUNT) ? {16'h0000, count} : `RST_WORD;
   wire status_clr = rd_acc & (idx == `REG_STATUS);
   // A new event in the clearing cycle survives the read
   wire [`EV_W-1:0] next_status = (status & {`EV_W{~status_clr}}) | ev_set;

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         status <= '0;
         mask <= `RST_MASK;
         count <= `RST_COUNT;
         wr_pend <= 1'b0;
         wr_idx <= 8'h00;
         hrdata_o <= `RST_WORD;
         hreadyout_o <= 1'b1;
         hresp_o <= `HRESP_OKAY;
         irq_o <= 1'b0;
      end else begin
         status <= next_status;
         if (wr_pend && wr_idx == `REG_MASK) begin
            mask <= hwdata_i[`EV_W-1:0];
         end
         // Count wraps at 16 bits; software must read it often enough
         count <= count + {15'h0000, delivered};
         wr_pend <= acc & hwrite_i;
         wr_idx <= idx;
         hrdata_o <= rd_acc ? rd_val : `RST_WORD;
         // Never stalls: every access completes in its own data phase
         hreadyout_o <= 1'b1;
         hresp_o <= `HRESP_OKAY;
         irq_o <= |(next_status & mask);
      end
   end

endmodule

// ---- adc_rx_model.sv ----
// Receiving logic that latches converter samples on the strobe edges
`timescale 1ns/1ps
module adc_rx_model
   import adc_out_pkg::*;
(
   input wire logic [1:0] mode_i,
   input wire sample_s a_i,
   input wire logic a_strobe_i,
   input wire sample_s b_i,
   input wire logic b_strobe_i,
   input wire sample_s d_i,
   input wire logic d_strobe_i,
   output sample_s a_o,
   output sample_s b_o,
   output sample_s d_o,
   output logic [7:0] na_o,
   output logic [7:0] nb_o,
   output logic [7:0] nd_o
);
   // Pairs are read as ideally terminated, the load being analog
   initial {na_o, nb_o, nd_o} = 24'h00_0000;
   always @(negedge a_strobe_i) begin
      a_o <= a_i;
      na_o <= na_o + 8'h01;
   end
   always @(negedge d_strobe_i) begin
      d_o <= d_i;
      nd_o <= nd_o + 8'h01;
   end
   // Bus B edge flips with the update style
   always @(b_strobe_i) begin
      if (b_strobe_i === (mode_i == 2'h1)) begin
         b_o <= b_i;
         nb_o <= nb_o + 8'h01;
      end
   end
endmodule

// ---- test_adc_output_mode_interface.sv ----
// Self-checking bench for the converter output block
`timescale 1ns/1ps
`include "adc_out_cfg.svh"
module test_adc_output_mode_interface import adc_out_pkg::*; ;
   localparam logic [31:0] NONE = 32'h0000_0000;
   logic sys_clk_i, rst_n_i, sample_clock_pos_i, sample_clock_neg_i, sample_range_i, chk;
   logic power_down_select_i, output_enable_n_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
   logic range_flag_pos_o, range_flag_neg_o, valid_strobe_pos_o, valid_strobe_neg_o, irq_o;
   logic diff_oe_o, first_bus_range_flag_o, first_bus_strobe_o, first_bus_oe_o;
   logic second_bus_range_flag_o, second_bus_oe_o, second_bus_strobe_o, second_strobe_oe_o;
   logic stabilizer_on_o;
   logic [1:0] format_level_i, output_mode_level_i, htrans_i;
   logic [2:0] hsize_i;
   logic [`SAMPLE_W-1:0] sample_code_i, diff_sample_bits_pos_o, diff_sample_bits_neg_o;
   logic [`SAMPLE_W-1:0] first_bus_bits_o, second_bus_bits_o;
   logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
   wire hready_i = hreadyout_o;
   wire [`SAMPLE_W:0] a_w = first_bus_oe_o ? {first_bus_range_flag_o, first_bus_bits_o} : 'z;
   wire [`SAMPLE_W:0] b_w = second_bus_oe_o ? {second_bus_range_flag_o, second_bus_bits_o} : 'z;
   wire [`SAMPLE_W:0] d_w = diff_oe_o ? {range_flag_pos_o, diff_sample_bits_pos_o} : 'z;
   wire sa_w = first_bus_oe_o ? first_bus_strobe_o : 1'bz;
   wire sb_w = second_strobe_oe_o ? second_bus_strobe_o : 1'bz;
   wire sd_w = diff_oe_o ? valid_strobe_pos_o : 1'bz;
   sample_s got_a, got_b, got_d;
   sample_s hist[256];
   logic [7:0] na, nb, nd;
   int rises, fails, samples_checked;
   int cyc = 0;
   int lat_a[4] = '{6, 8, 7, 6};
   int lat_b[4] = '{0, 7, 7, 0};
   adc_output_mode_interface adc_output_mode_interface_inst (.*);
   adc_rx_model adc_rx_model_inst (.mode_i(output_mode_level_i), .a_i(a_w), .a_strobe_i(sa_w),
      .b_i(b_w), .b_strobe_i(sb_w), .d_i(d_w), .d_strobe_i(sd_w), .a_o(got_a), .b_o(got_b),
      .d_o(got_d), .na_o(na), .nb_o(nb), .nd_o(nd));
   initial begin
      sys_clk_i = 1'b0;
      forever #25 sys_clk_i = ~sys_clk_i;
   end
   // Encode runs free at 400 ns; codes change at the fall so they stand well around each rise
   initial begin
      void'($urandom(97));
      {sample_clock_pos_i, sample_code_i, sample_range_i, rises} = '0;
      sample_clock_neg_i = 1'b1;
      forever begin
         repeat (4) @(posedge sys_clk_i);
         sample_clock_pos_i <= 1'b1;
         sample_clock_neg_i <= 1'b0;
         hist[rises[7:0]] <= {sample_range_i, sample_code_i};
         rises <= rises + 1;
         repeat (4) @(posedge sys_clk_i);
         sample_clock_pos_i <= 1'b0;
         sample_clock_neg_i <= 1'b1;
         sample_code_i <= rises[2:0] == 3'h0 ? {`SAMPLE_W{rises[3]}} : `SAMPLE_W'($urandom);
         sample_range_i <= 1'($urandom);
      end
   end
   function automatic sample_s want_at(int k);
      sample_s s;
      s = hist[k[7:0]];
      s.code[`SAMPLE_W-1] ^= format_level_i[1];
      return s;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      samples_checked++;
      if (seen !== want) begin
         fails++;
         $display("[FAIL] %0t seen %h want %h", $time, seen, want);
      end
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] q);
      hsel_i <= 1'b1;
      htrans_i <= 2'h2;
      haddr_i <= {24'h00_0000, a};
      hwrite_i <= wr;
      do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
      hsel_i <= 1'b0;
      htrans_i <= 2'h0;
      hwdata_i <= wd;
      do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
      q = hrdata_o;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] want);
      ahb(1'b0, a, NONE, rd);
      check(rd, want);
   endtask
   task automatic conclude;
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(na) if (chk) check(got_a, want_at(rises - lat_a[output_mode_level_i]));
   always @(nb) if (chk && ^output_mode_level_i)
      check(got_b, want_at(rises - lat_b[output_mode_level_i]));
   always @(nd) if (chk) check(got_d, want_at(rises - 6));
   always @(posedge sys_clk_i) begin
      cyc <= cyc + 1;
      if (cyc > 20000) begin
         fails++;
         conclude();
      end
   end
   initial begin
      {rst_n_i, hsel_i, hwrite_i, power_down_select_i, output_enable_n_i, chk} = '0;
      {format_level_i, output_mode_level_i, htrans_i, haddr_i, hwdata_i} = '0;
      {fails, samples_checked} = '0;
      hsize_i = `HSIZE_WORD;
      repeat (5) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      @(posedge sys_clk_i);
      for (int f = 0; f < 4; f++) begin
         for (int m = 0; m < 4; m++) begin
            chk <= 1'b0;
            format_level_i <= 2'(f);
            output_mode_level_i <= 2'(m);
            repeat (8) @(posedge sample_clock_pos_i);
            @(posedge sys_clk_i);
            chk <= 1'b1;
            check(stabilizer_on_o, ^format_level_i);
            rd_chk(`REG_STATE, {26'h000_0000, ^format_level_i, format_level_i[1],
               output_mode_level_i[1], ^output_mode_level_i, 2'h0});
            repeat (6) @(posedge sample_clock_pos_i);
            @(posedge sys_clk_i);
         end
      end
      chk <= 1'b0;
      output_mode_level_i <= 2'h0;
      power_down_select_i <= 1'b1;
      repeat (3) @(posedge sample_clock_pos_i);
      @(posedge sys_clk_i);
      check({diff_oe_o, first_bus_oe_o, second_bus_oe_o, second_strobe_oe_o}, NONE);
      rd_chk(`REG_STATE, 32'h0000_0011);
      ahb(1'b1, `REG_MASK, 32'h0000_0004, rd);
      ahb(1'b0, `REG_STATUS, NONE, rd);
      repeat (2) @(posedge sys_clk_i);
      check(irq_o, 1'b0);
      rd_chk(`REG_STATUS, NONE);
      output_enable_n_i <= 1'b1;
      repeat (10) @(posedge sys_clk_i);
      rd_chk(`REG_STATE, 32'h0000_0013);
      power_down_select_i <= 1'b0;
      repeat (4) @(posedge sample_clock_pos_i);
      @(posedge sys_clk_i);
      check({diff_oe_o, first_bus_oe_o, second_bus_oe_o, second_strobe_oe_o}, NONE);
      check(irq_o, 1'b1);
      ahb(1'b1, `REG_MASK, NONE, rd);
      repeat (2) @(posedge sys_clk_i);
      check(irq_o, 1'b0);
      ahb(1'b1, 8'h10, 32'h0000_0007, rd);
      rd_chk(8'h10, NONE);
      rd_chk(`REG_MASK, NONE);
      conclude();
   end
endmodule
bind adc_output_mode_interface adc_out_properties adc_out_properties_inst (.*);
